// file: sps_slave.sv
/*
  spi slave port: apb register slave, link synchroniser, bit counter,
  double-buffered transmit and buffered receive.
  assumes an external master drives sck, mosi and nss_n, all
  asynchronous to i_mclk and slow enough for edge detection.
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "sps_defines.svh"

module sps_slave #(
  parameter int ADDR_W = 12
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output var  logic [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_sck,
  input  wire logic              i_mosi,
  input  wire logic              i_nss_n,
  output var  logic              o_miso,
  output var  logic              o_miso_oe
);

  // elaboration check on the address width
  if (ADDR_W != 12) begin : g_chk
    $error("sps_slave: ADDR_W must be 12");
  end

  sps_pkg::sps_link_t link_s1;
  sps_pkg::sps_link_t link_s2;
  sps_pkg::sps_link_t link_s3;
  sps_pkg::sps_cfg_t  cfg;
  logic       ctrl_en;
  logic [1:0] mode;
  logic       done;
  logic [2:0] cnt;
  logic [7:0] rx_sh;
  logic [7:0] rx_buf;
  logic       rx_full;
  logic [7:0] tx_sh;
  logic [7:0] tx_buf;
  logic       tx_pend;
  logic       sh_empty;
  logic       sel_flt;

  // two-flop synchroniser plus one delay stage for edges
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      link_s1 <= 3'b001;
      link_s2 <= 3'b001;
      link_s3 <= 3'b001;
    end else begin
      link_s1 <= {i_sck, i_mosi, i_nss_n};
      link_s2 <= link_s1;
      link_s3 <= link_s2;
    end
  end

  // mode and activity decode
  wire three_wire = (mode == `SPS_MODE_3W);
  wire slave_on   = ctrl_en & ~cfg.master_enable;
  wire active     = slave_on & (three_wire | ~link_s2.nss_n);

  // serial clock edges relative to the idle level
  wire lead  = active & (link_s2.sck != cfg.cpol)
                      & (link_s3.sck == cfg.cpol);
  wire trail = active & (link_s2.sck == cfg.cpol)
                      & (link_s3.sck != cfg.cpol);
  wire smp   = cfg.cpha ? trail : lead;
  wire shf   = cfg.cpha ? lead : trail;
  // opening edge of a byte; the closing edge sets shift-empty unless tx_buf or a data write loads the shifter
  wire sck_open = lead & (cnt == 3'h0);

  // counter clears: disable always, falling select in 4-wire only
  wire nss_fall = ~three_wire & link_s3.nss_n & ~link_s2.nss_n;
  wire cnt_clr  = ~ctrl_en | nss_fall;
  wire byte_end = smp & ~cnt_clr & (cnt == `SPS_LAST_BIT);
  wire [7:0] rx_next = {rx_sh[6:0], link_s2.mosi};
  wire [2:0] next_cnt = cnt_clr ? 3'h0 : (smp ? cnt + 3'h1 : cnt);

  // apb decode
  wire setup   = i_psel & ~i_penable;
  wire acc     = i_psel & i_penable;
  wire hit_ctl = (i_paddr == `SPS_ADR(`SPS_IDX_CTRL));
  wire hit_cfg = (i_paddr == `SPS_ADR(`SPS_IDX_CFG));
  wire hit_dat = (i_paddr == `SPS_ADR(`SPS_IDX_DATA));
  wire mapped  = hit_ctl | hit_cfg | hit_dat;
  wire wr_ctl  = acc & i_pwrite & hit_ctl;
  wire wr_cfg  = acc & i_pwrite & hit_cfg;
  wire wr_dat  = acc & i_pwrite & hit_dat;
  wire rd_dat  = acc & ~i_pwrite & hit_dat;
  assign o_pready  = acc;
  assign o_pslverr = acc & ~mapped;

  // transmit path selection
  wire ld_wr  = wr_dat & (sh_empty | (byte_end & ~tx_pend));
  wire buf_wr = wr_dat & ~ld_wr;
  wire ld_buf = byte_end & tx_pend;
  wire [7:0] next_tx = ld_wr ? i_pwdata[7:0] : (ld_buf ? tx_buf : tx_sh);

  // status views; master mode forces the empties high
  wire busy    = active & ((cnt != 3'h0) | (link_s2.sck != cfg.cpol));
  wire she_rd  = sh_empty | cfg.master_enable;
  wire rxe_rd  = ~rx_full | cfg.master_enable;
  wire [7:0] cfg_rd = {busy, cfg.master_enable, cfg.cpha, cfg.cpol,
                       sel_flt, link_s2.nss_n, she_rd, rxe_rd};
  wire [7:0] ctl_rd = {done, 3'h0, mode, 1'b0, ctrl_en};
  wire [7:0] dat_rd = byte_end ? rx_next : rx_buf;
  wire [7:0] rd_mux = hit_ctl ? ctl_rd :
                      hit_cfg ? cfg_rd :
                      hit_dat ? dat_rd : 8'h00;

  // read data captured in the setup cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup) begin
      o_prdata <= {24'h00_0000, rd_mux};
    end
  end

  // control register; done flag set wins over clear
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_en <= 1'b0;
      mode    <= `SPS_MODE_4W;
      done    <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctrl_en <= i_pwdata[`SPS_CTL_EN];
        mode    <= {i_pwdata[`SPS_CTL_MHI], i_pwdata[`SPS_CTL_MLO]};
      end
      if (byte_end) begin
        done <= 1'b1;
      end else if (wr_ctl && !i_pwdata[`SPS_CTL_DONE]) begin
        done <= 1'b0;
      end
    end
  end

  // configuration bits
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cfg <= 3'b000;
    end else if (wr_cfg) begin
      cfg <= i_pwdata[`SPS_CFG_MASTER_ENABLE:`SPS_CFG_CPOL];
    end
  end

  // bit counter and receive shifter
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt   <= 3'h0;
      rx_sh <= 8'h00;
    end else begin
      cnt <= next_cnt;
      if (smp) begin
        rx_sh <= rx_next;
      end
    end
  end

  // receive buffer; a new byte wins over a read
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_buf  <= 8'h00;
      rx_full <= 1'b0;
    end else if (byte_end) begin
      rx_buf  <= rx_next;
      rx_full <= 1'b1;
    end else if (rd_dat) begin
      rx_full <= 1'b0;
    end
  end

  // transmit buffer and shift register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_sh   <= 8'h00;
      tx_buf  <= 8'h00;
      tx_pend <= 1'b0;
    end else begin
      tx_sh   <= next_tx;
      tx_pend <= buf_wr | (tx_pend & ~ld_buf);
      if (buf_wr) begin
        tx_buf <= i_pwdata[7:0];
      end
    end
  end

  // shift-empty flag
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sh_empty <= 1'b1;
    end else if (ld_wr || ld_buf) begin
      sh_empty <= 1'b0;
    end else if (byte_end) begin
      sh_empty <= 1'b1;
    end else if (sck_open) begin
      sh_empty <= 1'b0;
    end
  end

  // miso bit follows the counter on shift edges and loads
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= active;
      if (shf || ld_wr || ld_buf) begin
        o_miso <= next_tx[~next_cnt];
      end
    end
  end

  // deglitched select: follows only after two equal samples
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sel_flt <= 1'b0;
    end else if (link_s2.nss_n == link_s3.nss_n) begin
      sel_flt <= ~link_s2.nss_n;
    end
  end

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_NO_SELF_START: assert property (
    !active |=> $stable(rx_sh) && $stable(done) || $past(wr_ctl))
    else $error("shifter moved while not selected");

  AST_COUNT_STEP: assert property (
    smp && !cnt_clr |=> cnt == $past(cnt) + 3'h1)
    else $error("bit counter did not step");

  AST_BYTE_DONE: assert property (
    byte_end |=> done && rx_full && rx_buf == $past(rx_next))
    else $error("byte end did not post data");

  AST_LOAD_NOW: assert property (
    wr_dat && sh_empty |=> tx_sh == $past(i_pwdata[7:0]) && !sh_empty)
    else $error("write to empty shifter not loaded");

  AST_HOLD_PEND: assert property (
    tx_pend && !byte_end |=> $stable(tx_sh))
    else $error("shifter reloaded before last edge");

  AST_DESELECT_OFF: assert property (
    !three_wire && link_s2.nss_n |=> !o_miso_oe)
    else $error("miso driven while deselected");

  AST_NSS_CLEAR: assert property (
    nss_fall |=> cnt == 3'h0)
    else $error("select fall did not clear counter");

  AST_3W_KEEP: assert property (
    three_wire && ctrl_en && !smp && !wr_ctl |=> $stable(cnt))
    else $error("counter cleared in 3-wire mode");

  AST_RX_READ: assert property (
    rd_dat && !byte_end |=> !rx_full ##1 rxe_rd || $past(byte_end))
    else $error("read did not empty receive buffer");

  AST_SH_DRAIN: assert property (
    byte_end && !tx_pend && !wr_dat |=> sh_empty)
    else $error("shift empty not set at drain");

  AST_SHIFT_IN: assert property (
    smp |=> rx_sh == {$past(rx_sh[6:0]), $past(link_s2.mosi)})
    else $error("receive shifter took wrong bit");

  AST_MISO_STEP: assert property (
    shf && !ld_wr && !ld_buf |=> o_miso == $past(tx_sh[~next_cnt]))
    else $error("miso did not show the next bit");

  AST_MISO_HOLD: assert property (
    !shf && !ld_wr && !ld_buf |=> $stable(o_miso))
    else $error("miso moved off a shift edge");

  AST_OE_ACTIVE: assert property (
    active |=> o_miso_oe)
    else $error("miso not driven while active");

  AST_BUSY_MID: assert property (
    active && cnt != 3'h0 |-> busy)
    else $error("busy low inside a byte");

  AST_IDLE_FREE: assert property (
    !active |-> !busy)
    else $error("busy high while inactive");

  AST_MASTER_OFF: assert property (
    cfg.master_enable |-> !active)
    else $error("slave active with master enable set");

  AST_MASTER_EMPTY: assert property (
    cfg.master_enable |-> she_rd && rxe_rd)
    else $error("empties not forced in master mode");

  AST_THREE_WIRE: assert property (
    three_wire && slave_on |-> active)
    else $error("three-wire slave not active");

  AST_FOUR_WIRE: assert property (
    !three_wire && slave_on && !link_s2.nss_n |-> active)
    else $error("selected four-wire slave not active");

  AST_MODE_WRITE: assert property (
    wr_ctl |=> mode == {$past(i_pwdata[`SPS_CTL_MHI]), $past(i_pwdata[`SPS_CTL_MLO])})
    else $error("select mode not taken from write");

  AST_CFG_WRITE: assert property (
    wr_cfg |=> cfg == $past(i_pwdata[`SPS_CFG_MASTER_ENABLE:`SPS_CFG_CPOL]))
    else $error("configuration bits not taken from write");

  AST_DONE_CLEAR: assert property (
    wr_ctl && !i_pwdata[`SPS_CTL_DONE] && !byte_end |=> !done)
    else $error("done flag not cleared by write of zero");

  AST_LOAD_BUF: assert property (
    ld_buf |=> tx_sh == $past(tx_buf) && !sh_empty)
    else $error("buffer not moved at byte end");

  AST_RX_WAIT: assert property (
    byte_end |=> !rxe_rd || cfg.master_enable)
    else $error("receive empty set with unread byte");

  AST_SEL_FLAG: assert property (
    link_s2.nss_n == link_s3.nss_n |=> sel_flt != $past(link_s2.nss_n))
    else $error("selected flag does not follow select");

  AST_PIN_RAW: assert property (
    setup && hit_cfg |=> o_prdata[`SPS_CFG_PIN] == $past(link_s2.nss_n))
    else $error("raw select bit not returned");

  AST_SHE_LOAD: assert property (
    ld_wr || ld_buf |=> !sh_empty)
    else $error("shift empty kept across a load");

  AST_SHE_OPEN: assert property (
    sck_open |=> !sh_empty)
    else $error("shift empty kept across first clock edge");

endmodule // sps_slave
`default_nettype wire

// file: sps_defines.svh
/*
  register indices, byte addresses, field positions, reset values and
  counts for the spi slave port. assumes a 12-bit apb byte address.
*/
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
// register indices; byte address is four times the index
`define SPS_IDX_CTRL 10'h0a0
`define SPS_IDX_CFG 10'h0a1
`define SPS_IDX_DATA 10'h0a2
`define SPS_ADR(idx) ({idx, 2'b00})
// config/status fields
`define SPS_CFG_BUSY 7
`define SPS_CFG_MASTER_ENABLE 6
`define SPS_CFG_CPHA 5
`define SPS_CFG_CPOL 4
`define SPS_CFG_SEL 3
`define SPS_CFG_PIN 2
`define SPS_CFG_SHE 1
`define SPS_CFG_RXE 0
`define SPS_CFG_RST 8'h07
// control fields
`define SPS_CTL_DONE 7
`define SPS_CTL_MHI 3
`define SPS_CTL_MLO 2
`define SPS_CTL_EN 0
`define SPS_CTL_RST 8'h04
// select modes and byte length
`define SPS_MODE_3W 2'b00
`define SPS_MODE_4W 2'b01
`define SPS_LAST_BIT 3'h7
`endif

// file: sps_pkg.sv
/*
  types shared by the spi slave port.
  assumes sps_defines.svh is compiled alongside.
*/
`default_nettype none
package sps_pkg;
  // one sample of the serial link pins
  typedef struct packed {
    logic sck;
    logic mosi;
    logic nss_n;
  } sps_link_t;
  // software-set configuration bits
  typedef struct packed {
    logic master_enable;
    logic cpha;
    logic cpol;
  } sps_cfg_t;
endpackage
`default_nettype wire

// file: sps_mmod.sv
/* spi master model driving the slave port's link pins.
   assumes cpol and cpha are only changed between frames. */
`timescale 1ns/10ps
`default_nettype none
module sps_mmod (
  input  wire logic i_mclk,
  input  wire logic i_miso,
  input  wire logic i_cpol,
  input  wire logic i_cpha,
  output var  logic o_sck,
  output var  logic o_mosi,
  output var  logic o_nss_n
);
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_nss_n = 1'b1;
  end
  // wait n system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // one frame of n bits, msb first, sck period 8 clocks
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    tick(1);
    o_sck <= i_cpol;
    tick(2); // idle level settles before select falls
    o_nss_n <= 1'b0;
    tick(6);
    for (int i = 0; i < n; i++) begin
      if (!i_cpha) o_mosi <= tx[7-i];
      tick(2);
      o_sck <= ~i_cpol;
      if (i_cpha) o_mosi <= tx[7-i];
      tick(2);
      if (!i_cpha) rx = {rx[6:0], i_miso};
      tick(2);
      o_sck <= i_cpol;
      tick(2);
      if (i_cpha) rx = {rx[6:0], i_miso};
    end
    tick(4);
    o_mosi <= ~o_mosi; // stale data line flips
    o_nss_n <= 1'b1;
    tick(8);
  endtask
endmodule // sps_mmod
`default_nettype wire

// file: testbench.sv
/* self-checking bench for the spi slave port.
   assumes sps_slave and the master model sps_mmod are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "sps_defines.svh"
module testbench;
  localparam logic [11:0] A_CTL = `SPS_ADR(`SPS_IDX_CTRL);
  localparam logic [11:0] A_CFG = `SPS_ADR(`SPS_IDX_CFG);
  localparam logic [11:0] A_DAT = `SPS_ADR(`SPS_IDX_DATA);
  logic        mclk, rst, psel, penable, pwrite, tog, cpol, cpha, err;
  logic        pready, pslverr, sck, mosi, nss_n, miso, miso_oe, miso_w;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  got;
  int          fail_count, comparisons;
  // rows: cpol, cpha, byte to send, byte the master sends
  logic [17:0] rows [4] = '{18'h0a53c, 18'h1817e, 18'h25ac3, 18'h30ff0};

  // undriven miso toggles every clock
  assign miso_w = miso_oe ? miso : tog;
  always #5 mclk = ~mclk;
  always @(posedge mclk) tog <= ~tog;

  sps_slave u_sps_slave (.i_mclk(mclk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sck(sck), .i_mosi(mosi),
    .i_nss_n(nss_n), .o_miso(miso), .o_miso_oe(miso_oe));
  sps_mmod u_sps_mmod (.i_mclk(mclk), .i_miso(miso_w), .i_cpol(cpol), .i_cpha(cpha),
    .o_sck(sck), .o_mosi(mosi), .o_nss_n(nss_n));

  task automatic final_report();
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, pready waited for under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask

  initial begin
    {mclk, psel, penable, pwrite, tog, cpol, cpha} = 7'h0;
    rst = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    // reset values and an unmapped place
    rchk("cfg reset", A_CFG, `SPS_CFG_RST);
    rchk("ctl reset", A_CTL, `SPS_CTL_RST);
    rchk("unmapped", 12'h28c, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, err});
    // one byte each way in all four clock modes
    foreach (rows[i]) begin
      cpol <= rows[i][17];
      cpha <= rows[i][16];
      apb(1'b1, A_CFG, {2'b00, rows[i][16], rows[i][17], 4'h0});
      apb(1'b1, A_CTL, 8'h05);
      apb(1'b1, A_DAT, rows[i][15:8]);
      u_sps_mmod.xfer(rows[i][7:0], 8, got);
      chk("miso byte", {24'h0, rows[i][15:8]}, {24'h0, got});
      rchk("done flag", A_CTL, 8'h85);
      rchk("status", A_CFG, {2'b00, rows[i][16], rows[i][17], 4'h6});
      rchk("rx byte", A_DAT, rows[i][7:0]);
      rchk("rx empty", A_CFG, {2'b00, rows[i][16], rows[i][17], 4'h7});
    end
    // second write waits in the buffer
    apb(1'b1, A_DAT, 8'h3c);
    apb(1'b1, A_DAT, 8'hc3);
    rchk("shift full", A_CFG, 8'h35);
    u_sps_mmod.xfer(8'h00, 8, got);
    chk("first byte", 32'h3c, {24'h0, got});
    u_sps_mmod.xfer(8'h00, 8, got);
    chk("second byte", 32'hc3, {24'h0, got});
    // partial byte, then a select fall realigns
    u_sps_mmod.xfer(8'hff, 3, got);
    u_sps_mmod.xfer(8'h69, 8, got);
    rchk("realigned", A_DAT, 8'h69);
    // three-wire: only an enable toggle realigns
    apb(1'b1, A_CTL, 8'h01);
    u_sps_mmod.xfer(8'hff, 3, got);
    apb(1'b1, A_CTL, 8'h00);
    apb(1'b1, A_CTL, 8'h01);
    u_sps_mmod.xfer(8'h96, 8, got);
    rchk("three-wire", A_DAT, 8'h96);
    // three-wire: select falls do not realign a partial byte
    u_sps_mmod.xfer(8'h00, 3, got);
    u_sps_mmod.xfer(8'hff, 8, got);
    apb(1'b1, A_DAT, 8'h5a);
    // master enable set: link traffic ignored, empties forced
    cpol <= 1'b0;
    cpha <= 1'b0;
    apb(1'b1, A_CFG, 8'h40);
    apb(1'b1, A_CTL, 8'h05);
    u_sps_mmod.xfer(8'h12, 8, got);
    rchk("no slave", A_CTL, 8'h05);
    rchk("master empties", A_CFG, 8'h47);
    rchk("misaligned byte", A_DAT, 8'h1f);
    // reset in mid-run brings back the reset values
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rchk("cfg reset again", A_CFG, `SPS_CFG_RST);
    rchk("ctl reset again", A_CTL, `SPS_CTL_RST);
    final_report();
  end
endmodule // testbench
`default_nettype wire
